/* File: cepc_pkg.sv */
// package of constants for the core event priority controller
`default_nettype none
package cepc_pkg;
    localparam int unsigned CEPC_NUM_LEVELS = 16;
    localparam int unsigned CEPC_LVL_W = 4;
    localparam logic [3:0] CEPC_LVL_DEBUG = 4'h0;
    localparam logic [3:0] CEPC_LVL_RESET = 4'h1;
    localparam logic [3:0] CEPC_LVL_NMI = 4'h2;
    localparam logic [3:0] CEPC_LVL_EXCEPT = 4'h3;
    localparam logic [3:0] CEPC_LVL_GLOBAL = 4'h4;
    localparam logic [3:0] CEPC_LVL_HWERR = 4'h5;
    localparam logic [3:0] CEPC_LVL_TIMER = 4'h6;
    localparam logic [3:0] CEPC_LVL_GEN_FIRST = 4'h7;
    localparam logic [3:0] CEPC_LVL_PERIPH_LAST = 4'hD;
    localparam logic [3:0] CEPC_LVL_GEN_LAST = 4'hF;
    localparam int unsigned CEPC_NUM_PERIPH_LVLS = 7;
    localparam int unsigned CEPC_NUM_SRC = 16;
    localparam int unsigned CEPC_ADDR_W = 32;
    localparam logic [15:0] CEPC_ENABLE_RESET = 16'h0000;
    localparam logic [31:0] CEPC_RETA_RESET = 32'h0000_0000;
    // first event classes, always taken regardless of the global enable
    localparam logic [15:0] CEPC_NONMASKABLE = 16'h000F;
    typedef enum logic [1:0] {
        CEPC_ST_IDLE = 2'b00,
        CEPC_ST_TAKE = 2'b01
    } cepc_state_t;
endpackage
`default_nettype wire

/* File: cepc_core_event_priority_controller.sv */
// core event stage plus system interrupt router for one core
`default_nettype none
// operation in brief:
// - every raise is latched into a sticky pending bit, one per class
// - the class index is also its priority, 0 highest and 15 lowest
// - classes 0..3 ignore the global enable, 5..15 need both enables
// - class 4 stands for the global enable itself and is never raised
// - peripheral sources land on levels 7..13 through a writable map
// - levels 14 and 15 are left to software raises on soft_irq_i
// - an offer waits on take_o until the sequencer accepts it
// - acceptance sets the active bit and stores pc_i as return address
// - a return clears the highest active bit and shows its address
// limitations:
// - a class that outranks the standing offer waits until it is accepted
// - returns are refused while an offer stands, so the handshake stays atomic
// - the map only holds levels 7..13; writes naming other levels are dropped
// - one return address per class, so a class cannot nest over itself
// timing:
// - raise sampled at edge n shows on pending_o after n
// - the offer rises after edge n+1 at the earliest
// - accept sampled at edge m drops take_o and sets active_o after m
// - return sampled at edge r updates active_o and return_addr_o after r
// trade-off:
// - the offer is registered, costing a cycle, so every output is a flop
module cepc_core_event_priority_controller
    import cepc_pkg::*;
#(
    parameter int unsigned NUM_SRC = CEPC_NUM_SRC,
    parameter int unsigned ADDR_W = CEPC_ADDR_W
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic debug_halt_event_i,
    input wire logic reset_event_i,
    input wire logic nmi_event_i,
    input wire logic exception_event_i,
    input wire logic hardware_error_event_i,
    input wire logic core_timer_event_i,
    input wire logic [NUM_SRC-1:0] periph_irq_i,
    input wire logic [15:0] soft_irq_i,
    input wire logic global_enable_i,
    input wire logic [15:0] level_enable_i,
    input wire logic map_wr_i,
    input wire logic [$clog2(NUM_SRC)-1:0] map_src_i,
    input wire logic [3:0] map_level_i,
    input wire logic [ADDR_W-1:0] pc_i,
    input wire logic accept_i,
    input wire logic return_i,
    output logic take_o,
    output logic [3:0] take_level_o,
    output logic [15:0] active_o,
    output logic [15:0] pending_o,
    output logic [ADDR_W-1:0] return_addr_o
);
    // source to level map, one entry per peripheral source
    logic [3:0] map_ff [NUM_SRC];
    logic [3:0] nxt_map [NUM_SRC];
    // sticky pending bits and the nesting mask of active classes
    logic [15:0] pend_ff;
    logic [15:0] nxt_pend;
    logic [15:0] act_ff;
    logic [15:0] nxt_act;
    // one return address per class
    logic [ADDR_W-1:0] reta_ff [CEPC_NUM_LEVELS];
    logic [ADDR_W-1:0] nxt_reta [CEPC_NUM_LEVELS];
    // offer handshake towards the sequencer
    logic take_ff;
    logic nxt_take;
    logic [3:0] lvl_ff;
    logic [3:0] nxt_lvl;
    // address shown after the last return
    logic [ADDR_W-1:0] rout_ff;
    logic [ADDR_W-1:0] nxt_rout;
    cepc_state_t st_ff;
    cepc_state_t nxt_st;
    // combinational helpers
    logic [15:0] raw;
    logic [15:0] eligible;
    logic [3:0] win;
    logic [3:0] act_top;
    logic win_v;
    logic act_v;

    // default map spreads sources over levels 7..13 in turn
    function automatic logic [3:0] default_map(input int unsigned s);
        default_map = CEPC_LVL_GEN_FIRST + 4'(s % CEPC_NUM_PERIPH_LVLS);
    endfunction

    // lowest set index wins, since index 0 is the highest priority
    function automatic logic [4:0] first_set(input logic [15:0] v);
        first_set = 5'h00;
        for (int i = CEPC_NUM_LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = {1'b1, 4'(i)};
            end
        end
    endfunction

    // routing: each source lands on its mapped general level
    // several sources on one level simply merge into one raise
    always_comb begin
        raw = 16'h0000;
        raw[CEPC_LVL_DEBUG] = debug_halt_event_i;
        raw[CEPC_LVL_RESET] = reset_event_i;
        raw[CEPC_LVL_NMI] = nmi_event_i;
        raw[CEPC_LVL_EXCEPT] = exception_event_i;
        raw[CEPC_LVL_HWERR] = hardware_error_event_i;
        raw[CEPC_LVL_TIMER] = core_timer_event_i;
        for (int i = CEPC_LVL_GEN_FIRST; i <= CEPC_LVL_GEN_LAST; i++) begin
            raw[i] = soft_irq_i[i];
        end
        for (int s = 0; s < NUM_SRC; s++) begin
            if (periph_irq_i[s]) begin
                raw[map_ff[s]] = 1'b1;
            end
        end
    end

    // mapping table writes; levels outside 7..13 are refused
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            nxt_map[s] = map_ff[s];
        end
        if (map_wr_i && map_level_i >= CEPC_LVL_GEN_FIRST
                && map_level_i <= CEPC_LVL_PERIPH_LAST) begin
            nxt_map[map_src_i] = map_level_i;
        end
    end

    // map register; reset restores the default spread
    always_ff @(posedge core_clk_i) begin
        for (int s = 0; s < NUM_SRC; s++) begin
            map_ff[s] <= reset_i ? default_map(s) : nxt_map[s];
        end
    end

    // eligibility: nonmaskable classes bypass the global enable
    always_comb begin
        eligible = pend_ff & CEPC_NONMASKABLE;
        if (global_enable_i) begin
            eligible = eligible | (pend_ff & level_enable_i & ~CEPC_NONMASKABLE);
        end
        // class 4 only names the global enable and is never offered
        eligible[CEPC_LVL_GLOBAL] = 1'b0;
        {win_v, win} = first_set(eligible);
        {act_v, act_top} = first_set(act_ff);
    end

    // pending, nesting and return address state
    // a raise is or-ed in every cycle, so pending never misses a pulse
    // the clear on acceptance touches only the offered class
    always_comb begin
        nxt_pend = pend_ff | raw;
        nxt_act = act_ff;
        nxt_st = st_ff;
        nxt_take = 1'b0;
        nxt_lvl = lvl_ff;
        nxt_rout = rout_ff;
        for (int i = 0; i < CEPC_NUM_LEVELS; i++) begin
            nxt_reta[i] = reta_ff[i];
        end
        // idle: serve a return first, else offer the best eligible class
        case (st_ff)
            CEPC_ST_IDLE: begin
                // only a strictly higher class may nest over the running one
                if (return_i && act_v) begin
                    nxt_act[act_top] = 1'b0;
                    nxt_rout = reta_ff[act_top];
                end else if (win_v && (!act_v || win < act_top)) begin
                    nxt_take = 1'b1;
                    nxt_lvl = win;
                    nxt_st = CEPC_ST_TAKE;
                end
            end
            // offer: hold class and level steady until the core accepts
            CEPC_ST_TAKE: begin
                nxt_take = 1'b1;
                if (accept_i) begin
                    // new raise in the same cycle survives the clear
                    nxt_pend[lvl_ff] = raw[lvl_ff];
                    nxt_act[lvl_ff] = 1'b1;
                    nxt_reta[lvl_ff] = pc_i;
                    nxt_take = 1'b0;
                    nxt_st = CEPC_ST_IDLE;
                end
            end
            // unused codes fall back to idle
            default: nxt_st = CEPC_ST_IDLE;
        endcase
    end

    // handshake and nesting registers, synchronous reset to idle
    // pending is cleared too, so raises seen during reset are dropped
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pend_ff <= CEPC_ENABLE_RESET;
            act_ff <= CEPC_ENABLE_RESET;
            st_ff <= CEPC_ST_IDLE;
            take_ff <= 1'b0;
            lvl_ff <= CEPC_LVL_DEBUG;
            rout_ff <= CEPC_RETA_RESET[ADDR_W-1:0];
        end else begin
            pend_ff <= nxt_pend;
            act_ff <= nxt_act;
            st_ff <= nxt_st;
            take_ff <= nxt_take;
            lvl_ff <= nxt_lvl;
            rout_ff <= nxt_rout;
        end
        // return addresses start cleared; a stray return with no active class leaves return_addr_o unchanged
        for (int i = 0; i < CEPC_NUM_LEVELS; i++) begin
            reta_ff[i] <= reset_i ? CEPC_RETA_RESET[ADDR_W-1:0] : nxt_reta[i];
        end
    end

    // every output comes straight from a register
    assign take_o = take_ff;
    assign take_level_o = lvl_ff;
    assign active_o = act_ff;
    assign pending_o = pend_ff;
    assign return_addr_o = rout_ff;
endmodule
`default_nettype wire

/* File: cepc_checker.sv */
// port assertions for the core event priority controller
`default_nettype none
module cepc_checker #(
    parameter int unsigned NUM_SRC = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic nmi_event_i,
    input wire logic accept_i,
    input wire logic return_i,
    input wire logic global_enable_i,
    input wire logic take_o,
    input wire logic [NUM_SRC-1:0] periph_irq_i,
    input wire logic [3:0] take_level_o,
    input wire logic [15:0] active_o,
    input wire logic [15:0] pending_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // an offer accepted by the core
    sequence s_acc; take_o && accept_i; endsequence
    property p_rst; disable iff (1'b0) reset_i |=> !take_o && active_o == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_acc; s_acc |=> active_o[$past(take_level_o)]; endproperty
    a_acc: assert property (p_acc) else $error("active bit not set");
    property p_nmi; nmi_event_i |=> pending_o[2]; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not pending");
    property p_map; |periph_irq_i |=> pending_o[13:7] != 7'h00; endproperty
    a_map: assert property (p_map) else $error("source not routed");
    property p_pend; take_o |-> pending_o[take_level_o] && take_level_o != 4'h4; endproperty
    a_pend: assert property (p_pend) else $error("offer not pending");
    property p_nest; take_o |-> (active_o & ~(16'hFFFE << take_level_o)) == 16'h0000; endproperty
    a_nest: assert property (p_nest) else $error("offer below active");
    property p_ge; $rose(take_o) && take_level_o > 4'h4 |-> $past(global_enable_i); endproperty
    a_ge: assert property (p_ge) else $error("masked offer");
    property p_hi;
        $rose(take_o) |-> ($past(pending_o) & 16'h000F & ~(16'hFFFF << take_level_o)) == 16'h0000;
    endproperty
    a_hi: assert property (p_hi) else $error("lower priority first");
    property p_ret; return_i && !take_o && active_o != 16'h0000 |=> $changed(active_o); endproperty
    a_ret: assert property (p_ret) else $error("return ignored");
endmodule
bind cepc_core_event_priority_controller cepc_checker #(.NUM_SRC(NUM_SRC)) i_chk (.core_clk_i,
    .reset_i, .nmi_event_i, .accept_i, .return_i, .global_enable_i, .take_o, .periph_irq_i,
    .take_level_o, .active_o, .pending_o);
`default_nettype wire

/* File: cepc_seq_model.sv */
// core sequencer model: accepts offers after a chosen delay
`default_nettype none
module cepc_seq_model (
    input wire logic clk_i,
    input wire logic take_i,
    input wire logic [3:0] level_i,
    input wire logic [1:0] dly_i,
    output logic acc_o = 1'b0,
    output logic [31:0] pc_o = 32'h0000_0000
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;
    // pc encodes the level so the bench knows each return address
    always @(posedge clk_i) begin
        #1;
        pc_o = {28'hA000_000, level_i};
        acc_o = take_i && cnt >= dly_i;
        cnt = take_i ? cnt + 2'h1 : 2'h0;
    end
endmodule
`default_nettype wire

/* File: cepc_core_event_priority_controller_tb_top.sv */
// self-checking bench for the event controller
`default_nettype none
module cepc_core_event_priority_controller_tb_top import cepc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 0, reset_i = 1, nmi_event_i = 0, hardware_error_event_i = 0;
    logic global_enable_i = 0, return_i = 0, map_wr_i = 0, accept_i, take_o;
    logic debug_halt_event_i = 0, reset_event_i = 0, exception_event_i = 0;
    logic core_timer_event_i = 0;
    logic [15:0] periph_irq_i = 0, soft_irq_i = 0, level_enable_i = 0, active_o, pending_o;
    logic [3:0] map_src_i = 0, map_level_i = 0, take_level_o;
    logic [1:0] dly = 0;
    logic [31:0] pc_i, return_addr_o;
    int err_count = 0, checks = 0;
    always #2 core_clk_i = ~core_clk_i;
    cepc_core_event_priority_controller i_dut (.core_clk_i, .reset_i, .nmi_event_i,
        .debug_halt_event_i, .reset_event_i, .exception_event_i,
        .hardware_error_event_i, .core_timer_event_i, .periph_irq_i, .soft_irq_i,
        .global_enable_i, .level_enable_i, .map_wr_i, .map_src_i, .map_level_i, .pc_i,
        .accept_i, .return_i, .take_o, .take_level_o, .active_o, .pending_o, .return_addr_o);
    cepc_seq_model i_seq (.clk_i(core_clk_i), .take_i(take_o), .level_i(take_level_o),
        .dly_i(dly), .acc_o(accept_i), .pc_o(pc_i));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // inputs move 1 ns after the edge, away from sampling
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // wait bounded for an offer, check its level, let the model accept it
    task take(input logic [3:0] l);
        int i;
        i = 0;
        while (take_o !== 1'b1 && i < 20) begin cyc(1); i++; end
        chk("level", {28'h0, l}, {28'h0, take_level_o});
        while (take_o === 1'b1 && i < 40) begin cyc(1); i++; end
    endtask
    task ret_chk(input logic [31:0] a);
        return_i = 1;
        cyc(1);
        return_i = 0;
        cyc(1);
        chk("reta", a, return_addr_o);
    endtask
    task t_nmi;
        nmi_event_i = 1;
        hardware_error_event_i = 1;
        cyc(1);
        {nmi_event_i, hardware_error_event_i} = 2'b00;
        take(CEPC_LVL_NMI);
        chk("act", 32'h4, {16'h0, active_o});
        ret_chk(32'hA000_0002);
        chk("pend", 32'h20, {16'h0, pending_o});
    endtask
    task t_prio;
        {global_enable_i, level_enable_i, soft_irq_i, dly} = {1'b1, 16'hFFFF, 16'h8000, 2'h2};
        cyc(1);
        soft_irq_i = 16'h0000;
        take(CEPC_LVL_HWERR);
        ret_chk(32'hA000_0005);
        take(CEPC_LVL_GEN_LAST);
        ret_chk(32'hA000_000F);
    endtask
    task t_map;
        {dly, periph_irq_i} = {2'h1, 16'h0200};
        cyc(1);
        periph_irq_i = 16'h0000;
        take(4'h9);
        nmi_event_i = 1;
        cyc(1);
        nmi_event_i = 0;
        take(CEPC_LVL_NMI);
        chk("act", 32'h204, {16'h0, active_o});
        ret_chk(32'hA000_0002);
        ret_chk(32'hA000_0009);
        {map_wr_i, map_src_i, map_level_i} = {1'b1, 4'h9, 4'hD};
        cyc(1);
        map_level_i = 4'hF; // refused level leaves mapping alone
        cyc(1);
        {map_wr_i, periph_irq_i} = {1'b0, 16'h0200};
        cyc(1);
        periph_irq_i = 16'h0000;
        take(CEPC_LVL_PERIPH_LAST);
        ret_chk(32'hA000_000D);
    endtask
    // dedicated classes raised together are served in priority order
    task t_cls;
        {debug_halt_event_i, reset_event_i, exception_event_i} = 3'h7;
        {core_timer_event_i, dly} = {1'b1, 2'h0};
        cyc(1);
        {debug_halt_event_i, reset_event_i, exception_event_i, core_timer_event_i} = 4'h0;
        take(CEPC_LVL_DEBUG);
        ret_chk(32'hA000_0000);
        take(CEPC_LVL_RESET);
        ret_chk(32'hA000_0001);
        take(CEPC_LVL_EXCEPT);
        ret_chk(32'hA000_0003);
        take(CEPC_LVL_TIMER);
        ret_chk(32'hA000_0006);
        chk("pend", 32'h0, {16'h0, pending_o});
    endtask
    task summarize;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        cyc(4);
        reset_i = 0;
        chk("idle", 32'h0, {active_o, pending_o});
        chk("idle_take", 32'h0, {31'h0, take_o});
        t_nmi();
        t_prio();
        t_map();
        t_cls();
        summarize();
    end
    // cut a hang short well past the expected run time
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
